// file: lmi_map.svh
// offsets, field positions, reset values and timing counts of the laser mode interlock
`ifndef LMI_MAP_SVH
`define LMI_MAP_SVH

// clock rate and documented times
`define LMI_CLK_KHZ          40000
`define LMI_GUIDE_DELAY_MS   10
`define LMI_PROG_TICK_MS     1

// register byte offsets
`define LMI_REG_CONFIG       8'h00
`define LMI_REG_COMMAND      8'h04
`define LMI_REG_STATUS       8'h08
`define LMI_REG_INT_STAT     8'h0C
`define LMI_REG_INT_MASK     8'h10
`define LMI_REG_PROG_ADDR    8'h14
`define LMI_REG_PROG_DATA    8'h18

// config fields
`define LMI_CFG_ANALOG       0
`define LMI_CFG_EXT          1
`define LMI_CFG_PROG_LSB     8
`define LMI_CFG_PCT_LSB      16
`define LMI_CFG_RESET        32'h0000_0000

// command bits, write one to act
`define LMI_CMD_EMIT_ON      0
`define LMI_CMD_EMIT_OFF     1
`define LMI_CMD_GUIDE_ON     2
`define LMI_CMD_GUIDE_OFF    3
`define LMI_CMD_POWER_ON     4
`define LMI_CMD_POWER_OFF    5

// status bits
`define LMI_ST_READY         0
`define LMI_ST_POWER         1
`define LMI_ST_GUIDE         2
`define LMI_ST_EMIT          3
`define LMI_ST_RUNNING       4
`define LMI_ST_REMOTE        5
`define LMI_ST_PROG_MODE     6
`define LMI_ST_ANALOG        7

// interrupt bits
`define LMI_INT_PROG_DONE    0
`define LMI_INT_PROG_ABORT   1
`define LMI_INT_READY        2
`define LMI_INT_GUIDE        3
`define LMI_INT_MASK_RESET   4'h0

// pin vector positions
`define LMI_PIN_REMOTE       0
`define LMI_PIN_EMEN         1
`define LMI_PIN_ISEL         2
`define LMI_PIN_GUIDE        3
`define LMI_PIN_ASEL         4
`define LMI_PIN_MPWR         5
`define LMI_PIN_MOD          6
`define LMI_PIN_KEY          7
`define LMI_PIN_PANEL        8
`define LMI_PIN_PROG_LSB     9

`endif

// file: lmi_pkg.sv
// types of the laser mode interlock
package lmi_pkg;

	typedef enum logic [0:0] {
		RUN_IDLE,
		RUN_ACTIVE
	} lmi_run_t;

	typedef struct packed {
		logic [15:0] sync1;
		logic [15:0] sync2;
		logic [15:0] prev;
		logic        restored;
		logic        cfg_analog;
		logic        cfg_ext;
		logic [6:0]  cfg_prog;
		logic [7:0]  cfg_pct;
		logic        sw_emit;
		logic        sw_guide;
		logic        guide_lit;
		logic [19:0] guide_cnt;
		logic        main_power;
		logic        ready;
		logic        emit;
		logic        analog;
		logic [7:0]  pct;
		lmi_run_t    run;
		logic [7:0]  run_ms;
		logic [15:0] ms_cnt;
		logic [7:0]  run_pct;
		logic        abort_pulse;
		logic [3:0]  int_stat;
		logic [3:0]  int_mask;
		logic        irq;
		logic [31:0] rdata;
		logic [6:0]  prog_addr;
		logic        nv_wr;
		logic [1:0]  nv_data;
	} lmi_state_t;

endpackage

// file: lmi_prog_mem.sv
// stored emission programs: one word per program number
`timescale 1ns/1ps
module lmi_prog_mem (
	input  wire logic        i_clock,   // system clock
	input  wire logic        i_wr,      // write strobe
	input  wire logic [6:0]  i_waddr,   // write program number
	input  wire logic [15:0] i_wdata,   // {power pct, run time ms}
	input  wire logic [6:0]  i_raddr,   // read program number
	output logic      [15:0] o_rdata    // registered read data
);

	logic [15:0] mem [0:127];

	// no reset: contents are loaded by software before use
	always_ff @(posedge i_clock) begin
		if (i_wr) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end

endmodule

// file: lmi_core.sv
// laser mode interlock: mode select, guide beam, ready gate, program runs
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "lmi_map.svh"
module lmi_core #(
	parameter int unsigned GUIDE_DELAY_CYC = `LMI_GUIDE_DELAY_MS * `LMI_CLK_KHZ,
	parameter int unsigned TICK_CYC        = `LMI_PROG_TICK_MS * `LMI_CLK_KHZ
) (
	input  wire logic        i_clock,                  // 40 MHz clock
	input  wire logic        i_rstn,                   // async reset, low
	input  wire logic        i_remote_enable_input,    // pin, remote request
	input  wire logic        i_emission_enable_input,  // pin, emission enable
	input  wire logic        i_internal_select_input,  // pin, internal control
	input  wire logic        i_guide_beam_input,       // pin, guide level
	input  wire logic        i_analog_select_input,    // pin, analog power
	input  wire logic        i_main_power_input,       // pin, main power
	input  wire logic        i_modulation_input,       // pin, modulation
	input  wire logic        i_key_remote,             // pin, key switch at remote
	input  wire logic        i_panel_button,           // pin, front power button
	input  wire logic [6:0]  i_program_select_bus,     // pins, program number
	input  wire logic        i_supply_ok,              // internals ready to lase
	input  wire logic [1:0]  i_nv_data,                // kept selections
	input  wire logic [7:0]  i_addr,                   // register byte address
	input  wire logic [31:0] i_wdata,                  // register write data
	input  wire logic        i_wr,                     // write strobe
	input  wire logic        i_rd,                     // read strobe
	output logic      [31:0] o_rdata,                  // read data, cycle after
	output logic             o_irq,                    // interrupt level
	output logic             o_guide_beam,             // guide beam lit
	output logic             o_ready,                  // ready state
	output logic             o_main_power,             // main power on
	output logic             o_emit,                   // emission gate
	output logic             o_power_analog,           // power from analog input
	output logic      [7:0]  o_power_pct,              // set power percentage
	output logic             o_prog_running,           // program running
	output logic             o_prog_abnormal,          // abnormal end pulse
	output logic             o_nv_wr,                  // store selections pulse
	output logic      [1:0]  o_nv_data                 // selections to store
);

	lmi_pkg::lmi_state_t s_r;
	lmi_pkg::lmi_state_t s_nxt;

	localparam logic [19:0] GUIDE_LAST = 20'(GUIDE_DELAY_CYC - 1);
	localparam logic [15:0] TICK_LAST  = 16'(TICK_CYC - 1);

	logic [15:0] pins;
	logic [15:0] rise;
	logic [15:0] fall;
	logic [15:0] mem_rdata;
	logic        mem_wr;
	logic        remote;
	logic        ext_mode;
	logic        prog_mode;
	logic [6:0]  prog_num;
	logic        cmd_wr;
	logic        cfg_wr;
	logic [31:0] status;

	// pins gathered into one vector for the synchroniser
	assign pins = {i_program_select_bus, i_panel_button, i_key_remote,
		i_modulation_input, i_main_power_input, i_analog_select_input,
		i_guide_beam_input, i_internal_select_input, i_emission_enable_input,
		i_remote_enable_input};

	// edges only from the second stage onward, never the first
	assign rise = s_r.sync2 & ~s_r.prev;
	assign fall = ~s_r.sync2 & s_r.prev;

	// mode decode from synchronised levels
	assign remote    = s_r.sync2[`LMI_PIN_KEY] & s_r.sync2[`LMI_PIN_REMOTE];
	assign prog_num  = remote ? s_r.sync2[`LMI_PIN_PROG_LSB +: 7] : s_r.cfg_prog;
	assign prog_mode = (prog_num != 7'h0);
	assign ext_mode  = remote ? ~s_r.sync2[`LMI_PIN_ISEL] : s_r.cfg_ext;

	// register strobes
	assign cmd_wr = i_wr && (i_addr == `LMI_REG_COMMAND);
	assign cfg_wr = i_wr && (i_addr == `LMI_REG_CONFIG);
	assign mem_wr = i_wr && (i_addr == `LMI_REG_PROG_DATA);

	// status word
	always_comb begin
		status = 32'h0000_0000;
		status[`LMI_ST_READY]     = s_r.ready;
		status[`LMI_ST_POWER]     = s_r.main_power;
		status[`LMI_ST_GUIDE]     = s_r.guide_lit;
		status[`LMI_ST_EMIT]      = s_r.emit;
		status[`LMI_ST_RUNNING]   = (s_r.run == lmi_pkg::RUN_ACTIVE);
		status[`LMI_ST_REMOTE]    = remote;
		status[`LMI_ST_PROG_MODE] = prog_mode;
		status[`LMI_ST_ANALOG]    = s_r.analog;
	end

	// program store, read port follows the selected program number
	lmi_prog_mem u_mem (
		.i_clock (i_clock),
		.i_wr    (mem_wr),
		.i_waddr (s_r.prog_addr),
		.i_wdata (i_wdata[15:0]),
		.i_raddr (prog_num),
		.o_rdata (mem_rdata)
	);

	// next state
	always_comb begin
		logic       guide_want;
		logic       start;
		logic       stop;
		logic       done;
		logic       abort;
		logic       can_emit;
		logic [3:0] ev;
		guide_want = 1'b0;
		start      = 1'b0;
		stop       = 1'b0;
		done       = 1'b0;
		abort      = 1'b0;
		can_emit   = 1'b0;
		ev         = 4'h0;
		s_nxt      = s_r;

		// two-stage synchroniser then edge history
		s_nxt.sync1 = pins;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.prev  = s_r.sync2;
		s_nxt.abort_pulse = 1'b0;
		s_nxt.nv_wr = 1'b0;

		// kept selections come back once after reset release
		if (!s_r.restored) begin
			s_nxt.restored   = 1'b1;
			s_nxt.cfg_analog = i_nv_data[0];
			s_nxt.cfg_ext    = i_nv_data[1];
		end else if (cfg_wr) begin
			s_nxt.cfg_analog = i_wdata[`LMI_CFG_ANALOG];
			s_nxt.cfg_ext    = i_wdata[`LMI_CFG_EXT];
			s_nxt.cfg_prog   = i_wdata[`LMI_CFG_PROG_LSB +: 7];
			s_nxt.cfg_pct    = i_wdata[`LMI_CFG_PCT_LSB +: 8];
			// only a real change costs a nonvolatile write
			if ((i_wdata[`LMI_CFG_ANALOG] != s_r.cfg_analog) ||
				(i_wdata[`LMI_CFG_EXT] != s_r.cfg_ext)) begin
				s_nxt.nv_wr   = 1'b1;
				s_nxt.nv_data = {i_wdata[`LMI_CFG_EXT], i_wdata[`LMI_CFG_ANALOG]};
			end
		end

		// software guide commands, off wins if both written
		if (cmd_wr && i_wdata[`LMI_CMD_GUIDE_ON]) begin
			s_nxt.sw_guide = 1'b1;
		end
		if (cmd_wr && i_wdata[`LMI_CMD_GUIDE_OFF]) begin
			s_nxt.sw_guide = 1'b0;
		end

		// guide source: pin only in remote with internal select low
		if (remote && !s_r.sync2[`LMI_PIN_ISEL]) begin
			guide_want = s_r.sync2[`LMI_PIN_GUIDE];
		end else begin
			guide_want = s_r.sw_guide;
		end

		// guide module latency: change lands after the full delay
		if (guide_want == s_r.guide_lit) begin
			s_nxt.guide_cnt = 20'h0_0000;
		end else if (s_r.guide_cnt == GUIDE_LAST) begin
			s_nxt.guide_cnt = 20'h0_0000;
			s_nxt.guide_lit = guide_want;
			ev[`LMI_INT_GUIDE] = 1'b1;
		end else begin
			s_nxt.guide_cnt = s_r.guide_cnt + 20'h0_0001;
		end

		// main power: remote pin, panel button or software
		if (remote && rise[`LMI_PIN_MPWR]) begin
			s_nxt.main_power = 1'b1;
		end
		if (rise[`LMI_PIN_PANEL]) begin
			s_nxt.main_power = 1'b1;
		end
		if (cmd_wr && i_wdata[`LMI_CMD_POWER_ON]) begin
			s_nxt.main_power = 1'b1;
		end
		if (remote && fall[`LMI_PIN_MPWR]) begin
			s_nxt.main_power = 1'b0;
		end
		if (cmd_wr && i_wdata[`LMI_CMD_POWER_OFF]) begin
			s_nxt.main_power = 1'b0;
		end

		// ready held off while the guide beam is lit
		s_nxt.ready = s_r.main_power && i_supply_ok &&
			(s_r.ready || !s_r.guide_lit);
		if (s_nxt.ready && !s_r.ready) begin
			ev[`LMI_INT_READY] = 1'b1;
		end

		// software emission latch, dropped when not ready
		if (cmd_wr && i_wdata[`LMI_CMD_EMIT_ON]) begin
			s_nxt.sw_emit = 1'b1;
		end
		if ((cmd_wr && i_wdata[`LMI_CMD_EMIT_OFF]) || !s_r.ready) begin
			s_nxt.sw_emit = 1'b0;
		end

		// program start and stop sources per mode
		if (remote) begin
			start = rise[`LMI_PIN_EMEN];
			stop  = !s_r.sync2[`LMI_PIN_EMEN];
		end else if (ext_mode) begin
			start = rise[`LMI_PIN_MOD];
			stop  = fall[`LMI_PIN_MOD];
		end else begin
			start = cmd_wr && i_wdata[`LMI_CMD_EMIT_ON];
			stop  = cmd_wr && i_wdata[`LMI_CMD_EMIT_OFF];
		end

		// program run: whole ms ticks of the stored run time
		case (s_r.run)
			lmi_pkg::RUN_IDLE: begin
				if (start && prog_mode && s_r.ready) begin
					s_nxt.run     = lmi_pkg::RUN_ACTIVE;
					s_nxt.run_ms  = mem_rdata[7:0];
					s_nxt.run_pct = mem_rdata[15:8];
					s_nxt.ms_cnt  = 16'h0000;
				end
			end
			lmi_pkg::RUN_ACTIVE: begin
				// an early stop is reported as an abnormal end
				if (stop || !s_r.ready || !prog_mode) begin
					abort = 1'b1;
				end else if (s_r.ms_cnt == TICK_LAST) begin
					s_nxt.ms_cnt = 16'h0000;
					if (s_r.run_ms <= 8'h01) begin
						done = 1'b1;
					end else begin
						s_nxt.run_ms = s_r.run_ms - 8'h01;
					end
				end else begin
					s_nxt.ms_cnt = s_r.ms_cnt + 16'h0001;
				end
				if (abort || done) begin
					s_nxt.run = lmi_pkg::RUN_IDLE;
				end
			end
			default: begin
				s_nxt.run = lmi_pkg::RUN_IDLE;
			end
		endcase
		s_nxt.abort_pulse = abort;
		ev[`LMI_INT_PROG_DONE]  = done;
		ev[`LMI_INT_PROG_ABORT] = abort;

		// emission gate per mode, never without ready
		if (prog_mode) begin
			can_emit = (s_nxt.run == lmi_pkg::RUN_ACTIVE);
		end else if (remote && ext_mode) begin
			can_emit = s_r.sync2[`LMI_PIN_MOD] && s_r.sync2[`LMI_PIN_EMEN];
		end else if (ext_mode) begin
			can_emit = s_r.sync2[`LMI_PIN_MOD];
		end else begin
			can_emit = s_nxt.sw_emit;
		end
		s_nxt.emit = can_emit && s_r.ready;

		// power source: analog pin in remote, kept selection in local, set power from the program while one runs
		s_nxt.analog = remote ? s_r.sync2[`LMI_PIN_ASEL] : s_r.cfg_analog;
		if (prog_mode && (s_nxt.run == lmi_pkg::RUN_ACTIVE)) begin
			s_nxt.analog = 1'b0;
			s_nxt.pct    = s_nxt.run_pct;
		end else begin
			s_nxt.pct    = s_r.cfg_pct;
		end

		// program store address
		if (i_wr && (i_addr == `LMI_REG_PROG_ADDR)) begin
			s_nxt.prog_addr = i_wdata[6:0];
		end

		// sticky events: a new event beats a same-cycle clear
		if (i_wr && (i_addr == `LMI_REG_INT_STAT)) begin
			s_nxt.int_stat = s_r.int_stat & ~i_wdata[3:0];
		end
		s_nxt.int_stat = s_nxt.int_stat | ev;
		if (i_wr && (i_addr == `LMI_REG_INT_MASK)) begin
			s_nxt.int_mask = i_wdata[3:0];
		end
		s_nxt.irq = |(s_nxt.int_stat & s_nxt.int_mask);

		// read data stand only in the cycle after the strobe
		s_nxt.rdata = 32'h0000_0000;
		if (i_rd) begin
			case (i_addr)
				`LMI_REG_CONFIG: begin
					s_nxt.rdata[`LMI_CFG_ANALOG] = s_r.cfg_analog;
					s_nxt.rdata[`LMI_CFG_EXT]    = s_r.cfg_ext;
					s_nxt.rdata[`LMI_CFG_PROG_LSB +: 7] = s_r.cfg_prog;
					s_nxt.rdata[`LMI_CFG_PCT_LSB +: 8]  = s_r.cfg_pct;
				end
				`LMI_REG_STATUS: begin
					s_nxt.rdata = status;
				end
				`LMI_REG_INT_STAT: begin
					s_nxt.rdata[3:0] = s_r.int_stat;
				end
				`LMI_REG_INT_MASK: begin
					s_nxt.rdata[3:0] = s_r.int_mask;
				end
				`LMI_REG_PROG_ADDR: begin
					s_nxt.rdata[6:0] = s_r.prog_addr;
				end
				default: begin
					s_nxt.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// state register, constants only under reset
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			s_r           <= '0;
			s_r.run       <= lmi_pkg::RUN_IDLE;
			s_r.cfg_prog  <= 7'(`LMI_CFG_RESET >> `LMI_CFG_PROG_LSB);
			s_r.int_mask  <= `LMI_INT_MASK_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign o_rdata         = s_r.rdata;
	assign o_irq           = s_r.irq;
	assign o_guide_beam    = s_r.guide_lit;
	assign o_ready         = s_r.ready;
	assign o_main_power    = s_r.main_power;
	assign o_emit          = s_r.emit;
	assign o_power_analog  = s_r.analog;
	assign o_power_pct     = s_r.pct;
	assign o_prog_running  = (s_r.run == lmi_pkg::RUN_ACTIVE);
	assign o_prog_abnormal = s_r.abort_pulse;
	assign o_nv_wr         = s_r.nv_wr;
	assign o_nv_data       = s_r.nv_data;

endmodule

// file: lmi_core_monitor.sv
// checker for the laser mode interlock ports
`timescale 1ns/1ps
module lmi_core_monitor #(
	parameter int unsigned GUIDE_DELAY_CYC = 400000
) (
	input wire logic        i_clock,                 // clock
	input wire logic        i_rstn,                  // reset
	input wire logic        i_remote_enable_input,   // pin
	input wire logic        i_emission_enable_input, // pin
	input wire logic        i_internal_select_input, // pin
	input wire logic        i_guide_beam_input,      // pin
	input wire logic        i_key_remote,            // pin
	input wire logic        i_supply_ok,             // internals ok
	input wire logic        i_rd,                    // read strobe
	input wire logic [31:0] o_rdata,                 // read data
	input wire logic        o_guide_beam,            // guide lit
	input wire logic        o_ready,                 // ready
	input wire logic        o_main_power,            // power
	input wire logic        o_emit,                  // emission
	input wire logic        o_prog_running,          // running
	input wire logic        o_prog_abnormal          // abnormal end
);
	logic        pin_mode; // guide follows the pin
	logic [1:0]  seen_r;   // mode and pin one edge ago
	logic [31:0] age_r;    // cycles since mode or pin moved

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);

	// age saturates so long idle spans never wrap
	assign pin_mode = i_key_remote & i_remote_enable_input & ~i_internal_select_input;
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			seen_r <= 2'h0;
			age_r  <= 32'h0000_0000;
		end else begin
			seen_r <= {pin_mode, i_guide_beam_input};
			if (seen_r != {pin_mode, i_guide_beam_input})
				age_r <= 32'h0000_0000;
			else if (age_r != 32'hFFFF_FFFF)
				age_r <= age_r + 32'h0000_0001;
		end
	end

	sequence s_run_remote;
		o_prog_running && i_key_remote && i_remote_enable_input && i_emission_enable_input;
	endsequence
	sequence s_emen_drop;
		!i_emission_enable_input [*2];
	endsequence

	a_guide_delay: assert property ($changed(o_guide_beam) && pin_mode |-> age_r >= GUIDE_DELAY_CYC)
		else $error("guide changed too early");
	a_guide_follow: assert property (pin_mode && age_r == GUIDE_DELAY_CYC + 6 |-> o_guide_beam == i_guide_beam_input)
		else $error("guide not following pin");
	a_ready_blocked: assert property (o_guide_beam && !o_ready |=> !o_ready)
		else $error("ready entered with guide lit");
	a_ready_power: assert property (!o_main_power || !i_supply_ok |=> !o_ready)
		else $error("ready without power");
	a_emen_stops: assert property (s_run_remote ##1 s_emen_drop |-> ##[0:4] !o_prog_running)
		else $error("program ran on without enable");
	a_abort_once: assert property (o_prog_abnormal |=> !o_prog_abnormal)
		else $error("abnormal pulse too long");
	a_abort_cause: assert property (o_prog_abnormal |-> $past(o_prog_running) && !o_prog_running)
		else $error("abnormal end without a run");
	a_emit_ready: assert property (o_emit |-> o_ready || $past(o_ready))
		else $error("emission while not ready");
	a_read_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
		else $error("read data outside read cycle");
endmodule

// file: lmi_host_model.sv
// control board model driving the pin levels
`timescale 1ns/1ps
module lmi_host_model (
	input  wire logic i_clock, // clock
	output logic      o_rem,   // remote enable
	output logic      o_emen,  // emission enable
	output logic      o_isel,  // internal select
	output logic      o_guide, // guide pin
	output logic      o_asel,  // analog select
	output logic      o_mpwr,  // main power
	output logic      o_mod,   // modulation
	output logic      o_key,   // key at remote
	output logic      o_panel, // panel button
	output logic [6:0] o_prog  // program select
);
	// lines idle low, as an open pin reads
	initial begin
		{o_rem, o_emen, o_isel, o_guide, o_asel, o_mpwr, o_mod, o_key, o_panel} = 9'h000;
		o_prog = 7'h00;
	end

	// mode pins move together just after an edge
	task automatic set_mode(input logic k, r, s, a, input logic [6:0] p);
		@(posedge i_clock);
		{o_key, o_rem, o_isel, o_asel} <= {k, r, s, a};
		o_prog <= p;
	endtask
	task automatic set_line(input logic g, m, e, d);
		@(posedge i_clock);
		{o_guide, o_mpwr, o_emen, o_mod} <= {g, m, e, d};
	endtask
	// number settles before enable rises
	task automatic remote_start(input logic [6:0] num);
		@(posedge i_clock);
		o_prog <= num;
		repeat (4) @(posedge i_clock);
		o_emen <= 1'b1;
	endtask
	// caller picks the span; short spans abort on purpose
	task automatic mod_hold(input int cycles);
		@(posedge i_clock);
		o_mod <= 1'b1;
		repeat (cycles) @(posedge i_clock);
		o_mod <= 1'b0;
	endtask
	// front button press, held long enough to pass the synchroniser
	task automatic press_panel;
		@(posedge i_clock);
		o_panel <= 1'b1;
		repeat (4) @(posedge i_clock);
		o_panel <= 1'b0;
	endtask
endmodule

// file: lmi_testbench.sv
// self-checking bench for the laser mode interlock
`timescale 1ns/1ps
`include "lmi_map.svh"
module testbench;
	localparam int GD = 20; // short guide delay
	localparam int TK = 10; // short program tick
	logic        i_clock, i_rstn, i_supply_ok, i_wr, i_rd;
	logic [1:0]  i_nv_data, o_nv_data;
	logic [7:0]  i_addr, o_power_pct;
	logic [31:0] i_wdata, o_rdata;
	logic        i_remote_enable_input, i_emission_enable_input, i_internal_select_input;
	logic        i_guide_beam_input, i_analog_select_input, i_main_power_input;
	logic        i_modulation_input, i_key_remote, i_panel_button;
	logic [6:0]  i_program_select_bus;
	logic        o_irq, o_guide_beam, o_ready, o_main_power, o_emit, o_power_analog;
	logic        o_prog_running, o_prog_abnormal, o_nv_wr;
	int          errors, n_checks;

	lmi_core #(.GUIDE_DELAY_CYC(GD), .TICK_CYC(TK)) dut (.i_clock, .i_rstn,
		.i_remote_enable_input, .i_emission_enable_input, .i_internal_select_input,
		.i_guide_beam_input, .i_analog_select_input, .i_main_power_input,
		.i_modulation_input, .i_key_remote, .i_panel_button, .i_program_select_bus,
		.i_supply_ok, .i_nv_data, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq,
		.o_guide_beam, .o_ready, .o_main_power, .o_emit, .o_power_analog, .o_power_pct,
		.o_prog_running, .o_prog_abnormal, .o_nv_wr, .o_nv_data);
	lmi_host_model hm (.i_clock, .o_rem(i_remote_enable_input),
		.o_emen(i_emission_enable_input), .o_isel(i_internal_select_input),
		.o_guide(i_guide_beam_input), .o_asel(i_analog_select_input),
		.o_mpwr(i_main_power_input), .o_mod(i_modulation_input), .o_key(i_key_remote),
		.o_panel(i_panel_button), .o_prog(i_program_select_bus));

	// 40 MHz clock
	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	// register port: one-cycle strobes, read data one cycle later
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		{i_wr, i_addr, i_wdata} <= {1'b1, a, d};
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_clock);
		{i_rd, i_addr} <= {1'b1, a};
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 chk(o_rdata, exp);
	endtask
	task automatic do_reset(input logic [1:0] nv);
		{i_nv_data, i_rstn} <= {nv, 1'b0};
		repeat (16) @(posedge i_clock);
		i_rstn <= 1'b1;
		repeat (2) @(posedge i_clock);
	endtask

	task automatic t_regs;
		rd(`LMI_REG_CONFIG, 32'h0000_0000);
		rd(`LMI_REG_STATUS, 32'h0000_0000);
		rd(`LMI_REG_INT_MASK, 32'h0000_0000);
		rd(8'h1C, 32'h0000_0000);
		wr(`LMI_REG_INT_MASK, 32'h0000_000F);
		rd(`LMI_REG_INT_MASK, 32'h0000_000F);
		wr(`LMI_REG_COMMAND, 32'h0000_0010);
		cyc(2);
		chk({o_main_power, o_ready}, 2'b11);
		wr(`LMI_REG_COMMAND, 32'h0000_0001);
		cyc(2);
		chk(o_emit, 1'b1);
		wr(`LMI_REG_COMMAND, 32'h0000_0022);
		cyc(2);
		chk({o_main_power, o_ready, o_emit}, 3'b000);
		hm.press_panel;
		cyc(1);
		chk(o_main_power, 1'b1);
		wr(`LMI_REG_COMMAND, 32'h0000_0020);
		cyc(2);
		chk(o_main_power, 1'b0);
		$display("t_regs done");
	endtask
	task automatic t_guide_pin;
		hm.set_mode(1'b1, 1'b1, 1'b0, 1'b0, 7'h00);
		hm.set_line(1'b1, 1'b0, 1'b0, 1'b0);
		cyc(GD);
		chk(o_guide_beam, 1'b0);
		cyc(8);
		chk(o_guide_beam, 1'b1);
		hm.set_line(1'b1, 1'b1, 1'b0, 1'b0);
		cyc(8);
		chk({o_main_power, o_ready}, 2'b10);
		hm.set_line(1'b0, 1'b1, 1'b0, 1'b0);
		cyc(GD);
		chk(o_ready, 1'b0);
		cyc(8);
		chk({o_guide_beam, o_ready, o_irq}, 3'b011);
		rd(`LMI_REG_INT_STAT, 32'h0000_000C);
		wr(`LMI_REG_INT_STAT, 32'h0000_000C);
		cyc(2);
		chk(o_irq, 1'b0);
		$display("t_guide_pin done");
	endtask
	task automatic t_guide_sw;
		hm.set_mode(1'b1, 1'b1, 1'b1, 1'b0, 7'h00);
		hm.set_line(1'b1, 1'b1, 1'b0, 1'b0);
		cyc(GD + 8);
		chk(o_guide_beam, 1'b0);
		wr(`LMI_REG_COMMAND, 32'h0000_0004);
		cyc(GD + 6);
		chk(o_guide_beam, 1'b1);
		wr(`LMI_REG_COMMAND, 32'h0000_0008);
		hm.set_line(1'b0, 1'b1, 1'b0, 1'b0);
		cyc(GD + 6);
		chk({o_guide_beam, o_ready}, 2'b01);
		wr(`LMI_REG_INT_STAT, 32'h0000_000F);
		$display("t_guide_sw done");
	endtask
	task automatic t_remote_prog;
		wr(`LMI_REG_PROG_ADDR, 32'h0000_0003);
		wr(`LMI_REG_PROG_DATA, 32'h0000_4002);
		wr(`LMI_REG_INT_MASK, 32'h0000_0001);
		hm.remote_start(7'h03);
		cyc(6);
		chk(o_prog_running, 1'b1);
		rd(`LMI_REG_STATUS, 32'h0000_007B);
		cyc(2 * TK + 4);
		chk({o_prog_running, o_irq}, 2'b01);
		wr(`LMI_REG_INT_STAT, 32'h0000_0001);
		hm.set_line(1'b0, 1'b1, 1'b0, 1'b0);
		hm.remote_start(7'h03);
		cyc(6);
		chk(o_prog_running, 1'b1);
		hm.set_line(1'b0, 1'b1, 1'b0, 1'b0);
		cyc(6);
		chk({o_prog_running, o_irq}, 2'b00);
		rd(`LMI_REG_INT_STAT, 32'h0000_0002);
		wr(`LMI_REG_INT_STAT, 32'h0000_0002);
		wr(`LMI_REG_INT_MASK, 32'h0000_000F);
		$display("t_remote_prog done");
	endtask
	task automatic t_local_prog;
		hm.set_mode(1'b0, 1'b0, 1'b0, 1'b0, 7'h00);
		wr(`LMI_REG_CONFIG, 32'h0000_0302);
		hm.mod_hold(5);
		#1 chk(o_prog_running, 1'b1);
		cyc(3);
		chk({o_prog_running, o_prog_abnormal}, 2'b01);
		cyc(1);
		chk(o_prog_abnormal, 1'b0);
		rd(`LMI_REG_INT_STAT, 32'h0000_0002);
		wr(`LMI_REG_INT_STAT, 32'h0000_0002);
		hm.mod_hold(3 * TK + 10);
		cyc(4);
		rd(`LMI_REG_INT_STAT, 32'h0000_0001);
		wr(`LMI_REG_INT_STAT, 32'h0000_0001);
		$display("t_local_prog done");
	endtask
	task automatic t_emit;
		wr(`LMI_REG_CONFIG, 32'h0032_0002);
		hm.set_line(1'b0, 1'b1, 1'b0, 1'b1);
		cyc(6);
		chk({o_emit, o_power_pct}, 9'h132);
		hm.set_line(1'b0, 1'b1, 1'b0, 1'b0);
		cyc(6);
		chk(o_emit, 1'b0);
		hm.set_mode(1'b1, 1'b1, 1'b0, 1'b1, 7'h00);
		hm.set_line(1'b0, 1'b1, 1'b1, 1'b0);
		cyc(6);
		chk({o_emit, o_power_analog}, 2'b01);
		hm.set_line(1'b0, 1'b1, 1'b1, 1'b1);
		cyc(6);
		chk(o_emit, 1'b1);
		$display("t_emit done");
	endtask
	task automatic t_nv;
		wr(`LMI_REG_CONFIG, 32'h0000_0003);
		#1 chk(o_nv_wr, 1'b1);
		cyc(3);
		chk(o_nv_data, 2'b11);
		do_reset(2'b11);
		#1 chk(o_nv_wr, 1'b0);
		rd(`LMI_REG_CONFIG, 32'h0000_0003);
		$display("t_nv done");
	endtask

	task automatic test_done;
		$display("checks %0d, errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// main sequence
	initial begin
		{i_rstn, i_wr, i_rd, i_addr, i_wdata, i_nv_data} = '0;
		i_supply_ok = 1'b1;
		errors = 0;
		n_checks = 0;
		do_reset(2'b00);
		t_regs;
		t_guide_pin;
		t_guide_sw;
		t_remote_prog;
		t_local_prog;
		t_emit;
		t_nv;
		test_done;
	end
	// watchdog: the tests need well under 2000 cycles
	initial begin
		repeat (6000) @(posedge i_clock);
		errors++;
		test_done;
	end
endmodule

bind lmi_core lmi_core_monitor #(.GUIDE_DELAY_CYC(GUIDE_DELAY_CYC)) u_mon (.i_clock, .i_rstn,
	.i_remote_enable_input, .i_emission_enable_input, .i_internal_select_input,
	.i_guide_beam_input, .i_key_remote, .i_supply_ok, .i_rd, .o_rdata, .o_guide_beam,
	.o_ready, .o_main_power, .o_emit, .o_prog_running, .o_prog_abnormal);
